// ==== hw/adcp_output_control.sv ====
// Digital side of a pipelined sampling converter: sampling, format, power and output drive.
// Assumes all inputs except rst_n, including the sample clock, are synchronous to mclk.
`timescale 1ns/1ps
module adcp_output_control
	import adcp_pkg::*;
#(
	parameter int WIDTH   = RESULT_WIDTH,
	parameter int LATENCY = PIPE_LATENCY
) (
	input  wire logic                          mclk,
	input  wire logic                          rst_n,
	input  wire logic                          sampleClock,
	input  wire logic signed [INPUT_WIDTH-1:0] analogIn,
	input  wire logic                          power_down_select,
	input  wire logic                          outputEnable_n,
	input  wire logic [1:0]                    formatMode,
	output logic [WIDTH-1:0]                   conversion_result_bus,
	output logic [WIDTH-1:0]                   resultOe,
	output logic                               range_exceeded_flag,
	output logic                               flagOe,
	output logic                               twosComplement,
	output logic                               stabilizerOn,
	output logic [3:0]                         powerState
);

	// ==========================================================
	// Reset release
	logic rstMeta_n;
	logic rstSync_n;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_n <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_n <= 1'b1;
			rstSync_n <= rstMeta_n;
		end
	end

	// ==========================================================
	// Power state and format decode
	adcp_power_e power;
	adcp_power_e next_power;
	logic        next_twos;
	logic        next_stab;

	always_comb begin
		case ({power_down_select, outputEnable_n})
			2'b00:   next_power = ADCP_ACTIVE;
			2'b01:   next_power = ADCP_QUIET;
			2'b10:   next_power = ADCP_NAP;
			2'b11:   next_power = ADCP_SLEEP;
			default: next_power = ADCP_SLEEP;
		endcase
		case (formatMode)
			MODE_GND: begin
				next_twos = 1'b0;
				next_stab = 1'b0;
			end
			MODE_THIRD: begin
				next_twos = 1'b0;
				next_stab = 1'b1;
			end
			MODE_TWO_THIRDS: begin
				next_twos = 1'b1;
				next_stab = 1'b1;
			end
			MODE_SUPPLY: begin
				next_twos = 1'b1;
				next_stab = 1'b0;
			end
			default: begin
				next_twos = 1'b0;
				next_stab = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			power          <= ADCP_SLEEP;
			twosComplement <= 1'b0;
			stabilizerOn   <= 1'b0;
		end else begin
			power          <= next_power;
			twosComplement <= next_twos;
			stabilizerOn   <= next_stab;
		end
	end

	// ==========================================================
	// Sample edge, track and hold
	// Nap and sleep stop conversion; sleep also flushes the pipeline.
	logic                          prevClock;
	logic signed [INPUT_WIDTH-1:0] held;
	logic signed [INPUT_WIDTH-1:0] next_held;
	logic                          converting;
	logic                          sampleEdge;

	assign converting = (power == ADCP_ACTIVE) || (power == ADCP_QUIET);
	assign sampleEdge = sampleClock && !prevClock && converting;

	always_comb begin
		next_held = held;
		if (!sampleClock) begin
			next_held = analogIn;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			prevClock <= 1'b0;
			held      <= '0;
		end else begin
			prevClock <= sampleClock;
			held      <= next_held;
		end
	end

	// ==========================================================
	// Quantise the frozen sample to offset binary with range flag
	logic                          overRange;
	logic signed [INPUT_WIDTH-1:0] clamped;
	logic [WIDTH-1:0]              offsetCode;

	always_comb begin
		overRange = 1'b0;
		clamped   = held;
		if (held > IN_MAX) begin
			overRange = 1'b1;
			clamped   = IN_MAX;
		end else if (held < IN_MIN) begin
			overRange = 1'b1;
			clamped   = IN_MIN;
		end
		offsetCode = {~clamped[WIDTH-1], clamped[WIDTH-2:0]};
	end

	// ==========================================================
	// Held sample behind the launch edge
	// The held word enters the first stage on the next launch, so the
	// five stages behind it give five sample edges of latency, not four.
	logic [WIDTH-1:0] frozenWord;
	logic             frozenFlag;
	logic [WIDTH-1:0] next_frozenWord;
	logic             next_frozenFlag;

	always_comb begin
		next_frozenWord = frozenWord;
		next_frozenFlag = frozenFlag;
		if (power == ADCP_SLEEP) begin
			next_frozenWord = '0;
			next_frozenFlag = 1'b0;
		end else if (sampleEdge) begin
			next_frozenWord = offsetCode;
			next_frozenFlag = overRange;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			frozenWord <= '0;
			frozenFlag <= 1'b0;
		end else begin
			frozenWord <= next_frozenWord;
			frozenFlag <= next_frozenFlag;
		end
	end

	adcp_pipe_if #(.WIDTH(WIDTH)) pipeBus ();

	assign pipeBus.advance = sampleEdge;
	assign pipeBus.clear   = (power == ADCP_SLEEP);
	assign pipeBus.inWord  = frozenWord;
	assign pipeBus.inFlag  = frozenFlag;

	adcp_pipeline #(
		.WIDTH (WIDTH),
		.DEPTH (LATENCY)
	) u_pipeline (
		.clk       (mclk),
		.rstSync_n (rstSync_n),
		.pipe      (pipeBus)
	);

	// ==========================================================
	// Output word, flag and drive enables
	// Word and flag change in the same cycle so a capture sees one sample.
	logic [WIDTH-1:0] next_result;
	logic             next_flag;
	logic             next_drive;

	always_comb begin
		next_result = pipeBus.outWord;
		if (twosComplement) begin
			next_result[WIDTH-1] = ~pipeBus.outWord[WIDTH-1];
		end
		next_flag  = pipeBus.outFlag;
		next_drive = (power == ADCP_ACTIVE);
	end

	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			conversion_result_bus <= RESULT_RESET;
			range_exceeded_flag   <= 1'b0;
			resultOe              <= '0;
			flagOe                <= 1'b0;
			powerState            <= ADCP_SLEEP;
		end else begin
			conversion_result_bus <= next_result;
			range_exceeded_flag   <= next_flag;
			resultOe              <= {WIDTH{next_drive}};
			flagOe                <= next_drive;
			powerState            <= next_power;
		end
	end

endmodule

// ==== hw/adcp_pkg.sv ====
// Shared constants for the converter output control block.
// Assumes a single 40 MHz system clock; no register bus.
package adcp_pkg;

	// ==========================================================
	// Word layout and pipeline
	localparam int RESULT_WIDTH   = 14;
	localparam int INPUT_WIDTH    = RESULT_WIDTH + 1;
	localparam int PIPE_LATENCY   = 5;

	// Signed full-scale limits of the modelled analog input, in LSB
	localparam logic signed [INPUT_WIDTH-1:0] IN_MAX = 15'sh1FFF;
	localparam logic signed [INPUT_WIDTH-1:0] IN_MIN = -15'sh2000;

	// ==========================================================
	// Four-level format pin, quantised to two bits
	localparam logic [1:0] MODE_GND        = 2'h0;
	localparam logic [1:0] MODE_THIRD      = 2'h1;
	localparam logic [1:0] MODE_TWO_THIRDS = 2'h2;
	localparam logic [1:0] MODE_SUPPLY     = 2'h3;

	// ==========================================================
	// Power states, one-hot
	typedef enum logic [3:0] {
		ADCP_ACTIVE   = 4'h1,
		ADCP_QUIET    = 4'h2,
		ADCP_NAP      = 4'h4,
		ADCP_SLEEP    = 4'h8
	} adcp_power_e;

	localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 14'h0000;

endpackage

// ==== hw/adcp_pipe_if.sv ====
// Carrier between the control top and its conversion pipeline.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface adcp_pipe_if #(
	parameter int WIDTH = 14
);
	logic             advance;
	logic             clear;
	logic [WIDTH-1:0] inWord;
	logic             inFlag;
	logic [WIDTH-1:0] outWord;
	logic             outFlag;

	modport src (
		output advance,
		output clear,
		output inWord,
		output inFlag,
		input  outWord,
		input  outFlag
	);

	modport pipe (
		input  advance,
		input  clear,
		input  inWord,
		input  inFlag,
		output outWord,
		output outFlag
	);
endinterface

// ==== hw/adcp_pipeline.sv ====
// Fixed-latency conversion pipeline: word and flag move one stage per sample edge.
// Assumes advance is a one-cycle pulse and rstSync_n is already synchronised.
`timescale 1ns/1ps
module adcp_pipeline
	import adcp_pkg::*;
#(
	parameter int WIDTH = RESULT_WIDTH,
	parameter int DEPTH = PIPE_LATENCY
) (
	input  wire logic clk,
	input  wire logic rstSync_n,
	adcp_pipe_if.pipe pipe
);

	logic [WIDTH-1:0] stageWord [DEPTH];
	logic             stageFlag [DEPTH];

	// ==========================================================
	// Stages
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_stage
			logic [WIDTH-1:0] next_word;
			logic             next_flag;
			logic [WIDTH-1:0] srcWord;
			logic             srcFlag;

			if (i == 0) begin : g_head
				assign srcWord = pipe.inWord;
				assign srcFlag = pipe.inFlag;
			end else begin : g_body
				assign srcWord = stageWord[i-1];
				assign srcFlag = stageFlag[i-1];
			end

			always_comb begin
				next_word = stageWord[i];
				next_flag = stageFlag[i];
				if (pipe.clear) begin
					next_word = '0;
					next_flag = 1'b0;
				end else if (pipe.advance) begin
					next_word = srcWord;
					next_flag = srcFlag;
				end
			end

			always_ff @(posedge clk or negedge rstSync_n) begin
				if (!rstSync_n) begin
					stageWord[i] <= '0;
					stageFlag[i] <= 1'b0;
				end else begin
					stageWord[i] <= next_word;
					stageFlag[i] <= next_flag;
				end
			end
		end
	endgenerate

	assign pipe.outWord = stageWord[DEPTH-1];
	assign pipe.outFlag = stageFlag[DEPTH-1];

endmodule

// ==== tb/adcp_chk.sv ====
// Assertion checker on the converter control top ports.
// Assumes a single mclk domain; bound from the bench top file.
`timescale 1ns/1ps
module adcp_chk
	import adcp_pkg::*;
#(
	parameter int WIDTH   = RESULT_WIDTH,
	parameter int LATENCY = PIPE_LATENCY
) (
	input wire logic             mclk,
	input wire logic             rst_n,
	input wire logic             sampleClock,
	input wire logic             power_down_select,
	input wire logic             outputEnable_n,
	input wire logic [1:0]       formatMode,
	input wire logic [WIDTH-1:0] conversion_result_bus,
	input wire logic [WIDTH-1:0] resultOe,
	input wire logic             range_exceeded_flag,
	input wire logic             flagOe,
	input wire logic             twosComplement,
	input wire logic             stabilizerOn,
	input wire logic [3:0]       powerState
);
	// ==========================================================
	// Helpers
	logic [2:0] up;
	logic       rdy;
	logic [1:0] pins;
	assign rdy  = up == 3'h4;
	assign pins = {power_down_select, outputEnable_n};
	// Inner reset copy lingers two edges past release
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) up <= 3'h0;
		else if (!rdy) up <= up + 3'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Assertions
	property pState(logic [1:0] p, logic [3:0] s);
		(rdy && pins == p) [*2] |=> powerState == s &&
			(p == 2'h0 ? &resultOe && flagOe : !(|resultOe || flagOe));
	endproperty
	chk_state_active: assert property (pState(2'h0, 4'h1))
		else $error("Active state wrong");
	chk_state_quiet: assert property (pState(2'h1, 4'h2))
		else $error("Quiet state wrong");
	chk_state_nap: assert property (pState(2'h2, 4'h4))
		else $error("Nap state wrong");
	chk_state_sleep: assert property (pState(2'h3, 4'h8))
		else $error("Sleep state wrong");
	chk_format_pin: assert property ((rdy && $stable(formatMode)) [*3] |->
		twosComplement == formatMode[1] && stabilizerOn == ^formatMode)
		else $error("Format status wrong");
	chk_flag_clamp: assert property (rdy && range_exceeded_flag |->
		&conversion_result_bus[WIDTH-2:0] || ~|conversion_result_bus[WIDTH-2:0])
		else $error("Flag without clamped word");
	chk_word_launch: assert property (rdy && $changed({range_exceeded_flag,
		conversion_result_bus[WIDTH-2:0]}) |-> ($past(sampleClock, 2) && !$past(sampleClock, 3)) ||
		($past(powerState, 2) == 4'h8 && ~|conversion_result_bus[WIDTH-2:0] &&
		!range_exceeded_flag))
		else $error("Word moved without sample edge");
	chk_format_msb: assert property (rdy && !$past(sampleClock, 2) &&
		$past(powerState, 2) != 4'h8 && $changed(conversion_result_bus) |->
		(conversion_result_bus ^ $past(conversion_result_bus)) == {1'b1, {(WIDTH-1){1'b0}}})
		else $error("Format change touched low bits");
	cov_quiet: cover property (powerState == 4'h2 && !flagOe);
	cov_flag: cover property (range_exceeded_flag && flagOe);
	cov_twos: cover property (twosComplement && flagOe);
endmodule

// ==== tb/adcp_capture_model.sv ====
// Downstream capture logic on the far side of the result bus.
// Assumes released lines float; they show the inverse of the last capture.
`timescale 1ns/1ps
module adcp_capture_model
	import adcp_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic [RESULT_WIDTH-1:0] bus,
	input  wire logic [RESULT_WIDTH-1:0] busOe,
	input  wire logic                    flag,
	input  wire logic                    flagOe,
	output logic      [RESULT_WIDTH:0]   capture
);
	logic [RESULT_WIDTH:0] lvl;
	// Inverted lines keep a released bus from passing for a valid word
	assign lvl = {flagOe ? flag : ~capture[RESULT_WIDTH],
		bus & busOe | ~capture[RESULT_WIDTH-1:0] & ~busOe};
	always_ff @(posedge mclk) capture <= lvl;
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the converter output control block.
// Assumes the checker and capture model are compiled before it.
`timescale 1ns/1ps
module tb;
	import adcp_pkg::*;
	logic                          mclk, rst_n, sampleClock, power_down_select, outputEnable_n;
	logic signed [INPUT_WIDTH-1:0] analogIn;
	logic [1:0]                    formatMode;
	logic [RESULT_WIDTH-1:0]       conversion_result_bus, resultOe;
	logic                          range_exceeded_flag, flagOe, twosComplement, stabilizerOn;
	logic [3:0]                    powerState;
	logic [RESULT_WIDTH:0]         capture, note, notes[$];
	logic [6:0]                    pwrStat;
	logic [2:0]                    pend = 3'h0;
	logic                          prevSc = 1'b0;
	int                            err_total, total_checks, cycles, nEdge;
	logic signed [INPUT_WIDTH-1:0] edgeVals[4] = '{IN_MAX, IN_MAX + 15'sh0001, IN_MIN,
		IN_MIN - 15'sh0001};
	assign pwrStat = {powerState, &resultOe, |resultOe, flagOe};
	adcp_output_control dut (.mclk, .rst_n, .sampleClock, .analogIn, .power_down_select,
		.outputEnable_n, .formatMode, .conversion_result_bus, .resultOe, .range_exceeded_flag,
		.flagOe, .twosComplement, .stabilizerOn, .powerState);
	adcp_capture_model u_far (.mclk, .bus(conversion_result_bus), .busOe(resultOe),
		.flag(range_exceeded_flag), .flagOe, .capture);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic end_sim();
		$display("Checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmpSample(logic [RESULT_WIDTH:0] exp, logic [RESULT_WIDTH:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t sample exp %h got %h", $time, exp, got);
		end
	endtask
	task automatic cmpStat(logic [6:0] exp, logic [6:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t status exp %h got %h", $time, exp, got);
		end
	endtask
	// Garbage while low and while high: only the last low value may be held
	task automatic sample(logic signed [INPUT_WIDTH-1:0] v);
		logic signed [INPUT_WIDTH-1:0] c;
		c = v > IN_MAX ? IN_MAX : v < IN_MIN ? IN_MIN : v;
		sampleClock <= 1'b0;
		analogIn    <= ~v;
		@(posedge mclk);
		analogIn <= v;
		@(posedge mclk);
		sampleClock <= 1'b1;
		analogIn    <= 15'($urandom);
		notes.push_back({c != v, c[RESULT_WIDTH-1:0] ^ 14'h2000});
		@(posedge mclk);
	endtask
	task automatic burst(int n);
		repeat (n) sample(15'($urandom_range(18000)) - 15'sh2328);
	endtask
	// ==========================================================
	// Monitor: word leaves one edge after the fifth later launch
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		prevSc <= sampleClock;
		pend   <= {pend[1:0], sampleClock && !prevSc && nEdge >= PIPE_LATENCY};
		if (sampleClock && !prevSc) nEdge <= nEdge + 1;
		if (cycles == 2000) begin
			err_total++;
			end_sim();
		end
	end
	always @(negedge mclk) if (pend[2]) begin
		note = notes.pop_front() ^ {1'h0, formatMode[1], 13'h0000};
		if (flagOe) cmpSample(note, capture);
	end
	// ==========================================================
	// Main sequence
	initial begin
		{rst_n, sampleClock, power_down_select, outputEnable_n, formatMode} = 6'h00;
		analogIn = 15'h0000;
		void'($urandom(37128));
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		for (int m = 0; m < 4; m++) begin
			repeat (3) @(posedge mclk);
			formatMode <= 2'(m);
			// Sample clock low so a format flip shows up alone on the bus
			sampleClock <= 1'b0;
			repeat (4) @(negedge mclk);
			cmpStat({5'h00, m[1], m == 1 || m == 2}, {5'h00, twosComplement, stabilizerOn});
			@(posedge mclk);
			foreach (edgeVals[i]) sample(edgeVals[i]);
			burst(6);
		end
		for (int p = 0; p < 4; p++) begin
			repeat (3) @(posedge mclk);
			{power_down_select, outputEnable_n} <= 2'(p);
			repeat (3) @(negedge mclk);
			cmpStat({4'h1 << p, {3{p == 0}}}, pwrStat);
			@(posedge mclk);
			if (p == 1) begin
				burst(6);
				repeat (3) @(posedge mclk);
				{power_down_select, outputEnable_n} <= 2'h0;
				burst(6);
			end
		end
		end_sim();
	end
endmodule
bind adcp_output_control adcp_chk #(.WIDTH(WIDTH), .LATENCY(LATENCY)) u_chk (.mclk, .rst_n,
	.sampleClock, .power_down_select, .outputEnable_n, .formatMode, .conversion_result_bus,
	.resultOe, .range_exceeded_flag, .flagOe, .twosComplement, .stabilizerOn, .powerState);
